// file: srd_bitcount.sv
`timescale 1ns/100ps
module srd_bitcount
(
   srd_dec_if.cnt dif
);
   import srd_pkg::*;

   // ==========================================================
   // Registers chosen by the bitmap; bit 7 is data_reg_zero, bit 0 the frame base
   logic [3:0] acc [0:8];

   assign acc[0] = 4'h0;
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1)
      begin : g_bit
         assign acc[i+1] = acc[i] + {3'h0, dif.second_byte[i]};
      end
   endgenerate
   assign dif.set_count = acc[8];
endmodule

// file: srd_dec_if.sv
`timescale 1ns/100ps
interface srd_dec_if;
   import srd_pkg::*;
   logic [7:0] first_byte;
   logic [7:0] second_byte;
   logic one_byte;
   srd_op_type op;
   srd_kind_type kind;
   logic [3:0] sel;
   logic [3:0] len;
   logic [3:0] base_cyc;
   logic word;
   logic illegal;
   logic [1:0] push_bytes;
   logic [3:0] set_count;

   modport ctl (output first_byte, second_byte, input one_byte, op, kind, sel, len, base_cyc, word,
                illegal, push_bytes, set_count);
   modport dec (input first_byte, second_byte, output one_byte, op, kind, sel, len, base_cyc, word,
                illegal, push_bytes);
   modport cnt (input second_byte, output set_count);
endinterface

// file: srd_defs.svh
`ifndef SRD_DEFS_SVH
`define SRD_DEFS_SVH

// ==========================================================
// Register map (byte addresses, AXI4-Lite)
`define SRD_ADDR_W 5
`define SRD_OFF_CTRL 5'h00
`define SRD_OFF_MAC_COUNT 5'h04
`define SRD_OFF_STACK_PTR 5'h08
`define SRD_OFF_STATUS 5'h0C
`define SRD_OFF_RESULT 5'h10
`define SRD_OFF_OPCODE 5'h14
`define SRD_CTRL_ENABLE_RESET 1'h1
`define SRD_MAC_COUNT_RESET 8'h00
`define SRD_SP_RESET 16'h0000
`define SRD_RESP_OKAY 2'h0
`define SRD_RESP_SLVERR 2'h2

// ==========================================================
// Opcode encodings
`define SRD_PFX_IMM 7'h3E
`define SRD_B1_IMM 8'hE2
`define SRD_B1_MAC 8'hF1
`define SRD_PFX_OPND 7'h3A
`define SRD_B1_OPND_HI 4'h4
`define SRD_PFX_ROT 7'h3B
`define SRD_B1_ROT_HI 4'hA
`define SRD_B0_EA 8'h7D
`define SRD_B1_EA_HI 4'h9
`define SRD_B0_CTRL 8'hEB
`define SRD_B1_CTRL_LO 4'h2
`define SRD_B0_SET 8'hEC
`define SRD_SHORT_B_HI 4'h8
`define SRD_SHORT_W_HI 4'hC
`define SRD_SHORT_LO 3'h2

// ==========================================================
// Byte lengths and cycle counts
`define SRD_LEN_SHORT 4'h1
`define SRD_LEN_BASE 4'h2
`define SRD_LEN_IMM 4'h3
`define SRD_CYC_SHORT 4'h2
`define SRD_CYC_IMM 4'h2
`define SRD_CYC_OPND_REG 4'h2
`define SRD_CYC_OPND_MEM 4'h4
`define SRD_CYC_EA 4'h2
`define SRD_CYC_CTRL 4'h2
`define SRD_CYC_ROT_REG 4'h1
`define SRD_CYC_ROT_MEM 4'h3
`define SRD_CYC_MAC_B_BASE 16'h0004
`define SRD_CYC_MAC_B_PER 16'h0007
`define SRD_CYC_MAC_W_BASE 16'h0006
`define SRD_CYC_MAC_W_PER 16'h0009
`define SRD_CYC_MIN 16'h0001

`endif

// file: srd_fetch_model.sv
`timescale 1ns/100ps
// ==========================================================
// Fetch path model: offers queued bytes back to back
module srd_fetch_model
(
   input wire logic aclk,
   input wire logic fetch_ready,
   output logic fetch_valid,
   output logic [7:0] fetch_byte
);
   logic [7:0] q[$];
   initial
   begin
      fetch_valid = 1'b0;
      fetch_byte = 8'h00;
   end
   always @(posedge aclk)
   begin
      if (fetch_valid && fetch_ready && q.size() > 0)
         void'(q.pop_front());
      fetch_valid <= q.size() > 0;
      // Idle byte toggles so a stale value never looks like data
      fetch_byte <= q.size() > 0 ? q[0] : ~fetch_byte;
   end
endmodule

// file: srd_opdecode.sv
`timescale 1ns/100ps
`include "srd_defs.svh"
module srd_opdecode
(
   srd_dec_if.dec dif
);
   import srd_pkg::*;

   // ==========================================================
   // Operand code classes
   function automatic srd_kind_type kind_of(input logic [3:0] c);
      if (c[3:2] == 2'b00)
         return srd_kind_dreg;
      else if (c[3:1] == 3'b010)
         return srd_kind_areg;
      else if (c[3:1] == 3'b011)
         return srd_kind_aind;
      else if (c[3:2] == 2'b10)
         return srd_kind_displacement_byte;
      else if (c != 4'hF)
         return srd_kind_dsp16;
      else
         return srd_kind_abs;
   endfunction

   function automatic logic [3:0] extra_len(input srd_kind_type k);
      if (k == srd_kind_displacement_byte)
         return 4'h1;
      else if (k == srd_kind_dsp16 || k == srd_kind_abs)
         return 4'h2;
      else
         return 4'h0;
   endfunction

   logic [7:0] b0;
   logic [7:0] b1;
   srd_kind_type k1;

   assign b0 = dif.first_byte;
   assign b1 = dif.second_byte;
   assign k1 = kind_of(b1[3:0]);

   // ==========================================================
   // Decode table
   always_comb
   begin
      dif.one_byte = 1'b0;
      dif.op = srd_op_none;
      dif.kind = srd_kind_none;
      dif.sel = 4'h0;
      dif.len = `SRD_LEN_BASE;
      dif.base_cyc = 4'h1;
      dif.word = 1'b0;
      dif.illegal = 1'b1;
      dif.push_bytes = 2'h0;
      if (b0[7:4] == `SRD_SHORT_B_HI && b0[2:0] == `SRD_SHORT_LO)
      begin
         // data_reg_zero_low or data_reg_zero_high
         dif.one_byte = 1'b1;
         dif.op = srd_op_push_short_b;
         dif.kind = srd_kind_dreg;
         dif.sel = {3'h0, b0[3]};
         dif.len = `SRD_LEN_SHORT;
         dif.base_cyc = `SRD_CYC_SHORT;
         dif.illegal = 1'b0;
         dif.push_bytes = 2'h1;
      end
      else if (b0[7:4] == `SRD_SHORT_W_HI && b0[2:0] == `SRD_SHORT_LO)
      begin
         dif.one_byte = 1'b1;
         dif.op = srd_op_push_short_w;
         dif.kind = srd_kind_areg;
         dif.sel = {3'h0, b0[3]};
         dif.len = `SRD_LEN_SHORT;
         dif.base_cyc = `SRD_CYC_SHORT;
         dif.word = 1'b1;
         dif.illegal = 1'b0;
         dif.push_bytes = 2'h2;
      end
      else if (b0[7:1] == `SRD_PFX_IMM && b1 == `SRD_B1_IMM)
      begin
         dif.op = srd_op_push_imm;
         dif.word = b0[0];
         dif.len = `SRD_LEN_IMM + {3'h0, b0[0]};
         dif.base_cyc = `SRD_CYC_IMM;
         dif.illegal = 1'b0;
         dif.push_bytes = b0[0] ? 2'h2 : 2'h1;
      end
      else if (b0[7:1] == `SRD_PFX_IMM && b1 == `SRD_B1_MAC)
      begin
         // Cycles depend on the repeat count, resolved by the caller
         dif.op = srd_op_repeat_multiply_accumulate;
         dif.word = b0[0];
         dif.illegal = 1'b0;
      end
      else if (b0 == `SRD_B0_EA && b1[7:4] == `SRD_B1_EA_HI)
      begin
         dif.op = srd_op_push_effective_address;
         dif.kind = k1;
         dif.sel = b1[3:0];
         dif.len = `SRD_LEN_BASE + extra_len(k1);
         dif.base_cyc = `SRD_CYC_EA;
         dif.word = 1'b1;
         dif.illegal = ~b1[3];
         dif.push_bytes = 2'h2;
      end
      else if (b0[7:1] == `SRD_PFX_OPND && b1[7:4] == `SRD_B1_OPND_HI)
      begin
         dif.op = srd_op_push_opnd;
         dif.kind = k1;
         dif.sel = b1[3:0];
         dif.word = b0[0];
         dif.len = `SRD_LEN_BASE + extra_len(k1);
         dif.base_cyc = (k1 == srd_kind_dreg || k1 == srd_kind_areg) ? `SRD_CYC_OPND_REG
                                                                       : `SRD_CYC_OPND_MEM;
         dif.illegal = 1'b0;
         dif.push_bytes = b0[0] ? 2'h2 : 2'h1;
      end
      else if (b0[7:1] == `SRD_PFX_ROT && b1[7:4] == `SRD_B1_ROT_HI)
      begin
         dif.op = srd_op_rotate_left_through_carry;
         dif.kind = k1;
         dif.sel = b1[3:0];
         dif.word = b0[0];
         dif.len = `SRD_LEN_BASE + extra_len(k1);
         dif.base_cyc = (k1 == srd_kind_dreg || k1 == srd_kind_areg) ? `SRD_CYC_ROT_REG
                                                                       : `SRD_CYC_ROT_MEM;
         dif.illegal = 1'b0;
      end
      else if (b0 == `SRD_B0_CTRL && !b1[7] && b1[3:0] == `SRD_B1_CTRL_LO)
      begin
         dif.op = srd_op_push_control_reg;
         dif.kind = srd_kind_ctrl;
         dif.sel = {1'b0, b1[6:4]};
         dif.base_cyc = `SRD_CYC_CTRL;
         dif.word = 1'b1;
         dif.illegal = (b1[6:4] == 3'h0);
         dif.push_bytes = 2'h2;
      end
      else if (b0 == `SRD_B0_SET)
      begin
         dif.op = srd_op_push_register_set;
         dif.word = 1'b1;
         dif.illegal = 1'b0;
      end
   end
endmodule

// file: srd_pkg.sv
package srd_pkg;

   typedef enum logic [3:0] {
      srd_op_none,
      srd_op_push_imm,
      srd_op_push_opnd,
      srd_op_push_short_b,
      srd_op_push_short_w,
      srd_op_push_effective_address,
      srd_op_push_control_reg,
      srd_op_push_register_set,
      srd_op_repeat_multiply_accumulate,
      srd_op_rotate_left_through_carry
   } srd_op_type;

   typedef enum logic [2:0] {
      srd_kind_dreg,
      srd_kind_areg,
      srd_kind_aind,
      srd_kind_displacement_byte,
      srd_kind_dsp16,
      srd_kind_abs,
      srd_kind_ctrl,
      srd_kind_none
   } srd_kind_type;

   typedef enum logic [1:0] {
      st_idle,
      st_second,
      st_operand,
      st_exec
   } srd_state_type;

endpackage

// file: srd_top.sv
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`include "srd_defs.svh"
module srd_top
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`SRD_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`SRD_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic fetch_valid,
   input wire logic [7:0] fetch_byte,
   output logic fetch_ready,
   output logic insn_done,
   output srd_pkg::srd_op_type insn_op,
   output srd_pkg::srd_kind_type insn_kind,
   output logic [3:0] insn_sel,
   output logic [3:0] insn_len,
   output logic [15:0] insn_cycles,
   output logic insn_illegal,
   output logic stack_wr_en,
   output logic [15:0] stack_wr_addr,
   output logic [4:0] stack_wr_bytes
);
   import srd_pkg::*;

   srd_dec_if dif ();
   srd_opdecode u_dec (.dif(dif));
   srd_bitcount u_cnt (.dif(dif));

   srd_state_type state;
   logic [7:0] first_q;
   logic [7:0] second_q;
   logic [3:0] remain;
   logic [15:0] cyc_left;
   srd_op_type op_q;
   srd_kind_type kind_q;
   logic [3:0] sel_q;
   logic [3:0] len_q;
   logic [15:0] cyc_q;
   logic illegal_q;
   logic [4:0] push_q;
   logic [3:0] set_cnt_q;
   logic ctrl_enable;
   logic [7:0] mac_count;
   logic [15:0] stack_pointer;
   logic fire;
   logic decode_evt;
   logic done_evt;
   logic [15:0] calc_cycles;
   logic [4:0] calc_push;
   logic wr_fire;
   logic rd_fire;

   // ==========================================================
   // Fetch side
   assign fetch_ready = ctrl_enable && (state != st_exec);
   assign fire = fetch_valid && fetch_ready;
   assign dif.first_byte = (state == st_idle) ? fetch_byte : first_q;
   assign dif.second_byte = (state == st_second) ? fetch_byte : second_q;
   assign decode_evt = fire && ((state == st_idle && dif.one_byte) || state == st_second);
   assign done_evt = (state == st_exec) && (cyc_left == 16'h0001);

   always_comb
   begin
      calc_cycles = {12'h000, dif.base_cyc};
      calc_push = {3'h0, dif.push_bytes};
      if (dif.illegal)
      begin
         calc_cycles = `SRD_CYC_MIN;
         calc_push = 5'h00;
      end
      else if (dif.op == srd_op_push_register_set)
      begin
         // Empty bitmap still occupies one cycle
         calc_cycles = (dif.set_count == 4'h0) ? `SRD_CYC_MIN
                                               : {11'h000, dif.set_count, 1'b0};
         calc_push = {dif.set_count, 1'b0};
      end
      else if (dif.op == srd_op_repeat_multiply_accumulate)
      begin
         if (dif.word)
            calc_cycles = `SRD_CYC_MAC_W_BASE + `SRD_CYC_MAC_W_PER * {8'h00, mac_count};
         else
            calc_cycles = `SRD_CYC_MAC_B_BASE + `SRD_CYC_MAC_B_PER * {8'h00, mac_count};
      end
   end

   // ==========================================================
   // Sequencer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state <= st_idle;
      else
      begin
         unique case (state)
            st_idle:
               if (fire)
                  state <= dif.one_byte ? st_exec : st_second;
            st_second:
               if (fire)
                  state <= (!dif.illegal && dif.len > `SRD_LEN_BASE) ? st_operand : st_exec;
            st_operand:
               if (fire && remain == 4'h1)
                  state <= st_exec;
            st_exec:
               if (done_evt)
                  state <= st_idle;
         endcase
      end
   end

   // Trailing displacement, absolute and immediate bytes are counted off
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         first_q <= 8'h00;
         second_q <= 8'h00;
         remain <= 4'h0;
      end
      else
      begin
         if (fire && state == st_idle)
            first_q <= fetch_byte;
         if (fire && state == st_second)
         begin
            second_q <= fetch_byte;
            remain <= dif.len - `SRD_LEN_BASE;
         end
         else if (fire && state == st_operand)
            remain <= remain - 4'h1;
      end
   end

   // Decode results are frozen once the last opcode byte is in
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         op_q <= srd_op_none;
         kind_q <= srd_kind_none;
         sel_q <= 4'h0;
         len_q <= 4'h0;
         cyc_q <= 16'h0000;
         illegal_q <= 1'b0;
         push_q <= 5'h00;
         set_cnt_q <= 4'h0;
      end
      else if (decode_evt)
      begin
         op_q <= dif.op;
         kind_q <= dif.kind;
         sel_q <= dif.sel;
         len_q <= dif.len;
         cyc_q <= calc_cycles;
         illegal_q <= dif.illegal;
         push_q <= calc_push;
         set_cnt_q <= dif.set_count;
      end
   end

   // Execution timer: fetch is stalled for the whole count
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cyc_left <= 16'h0000;
      else if (decode_evt)
         cyc_left <= calc_cycles;
      else if (state == st_exec)
         cyc_left <= cyc_left - 16'h0001;
   end

   // ==========================================================
   // Completion report
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         insn_done <= 1'b0;
         insn_op <= srd_op_none;
         insn_kind <= srd_kind_none;
         insn_sel <= 4'h0;
         insn_len <= 4'h0;
         insn_cycles <= 16'h0000;
         insn_illegal <= 1'b0;
      end
      else
      begin
         insn_done <= done_evt;
         if (done_evt)
         begin
            insn_op <= op_q;
            insn_kind <= kind_q;
            insn_sel <= sel_q;
            insn_len <= len_q;
            insn_cycles <= cyc_q;
            insn_illegal <= illegal_q;
         end
      end
   end

   // Stack: pointer drops and the store is issued on the same edge, starting at the new top, low byte there
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         stack_pointer <= `SRD_SP_RESET;
         stack_wr_en <= 1'b0;
         stack_wr_addr <= 16'h0000;
         stack_wr_bytes <= 5'h00;
      end
      else
      begin
         stack_wr_en <= 1'b0;
         if (done_evt && !illegal_q && push_q != 5'h00)
         begin
            stack_pointer <= stack_pointer - {11'h000, push_q};
            stack_wr_en <= 1'b1;
            stack_wr_addr <= stack_pointer - {11'h000, push_q};
            stack_wr_bytes <= push_q;
         end
         else if (wr_fire && s_axi_awaddr == `SRD_OFF_STACK_PTR)
         begin
            if (s_axi_wstrb[0])
               stack_pointer[7:0] <= s_axi_wdata[7:0];
            if (s_axi_wstrb[1])
               stack_pointer[15:8] <= s_axi_wdata[15:8];
         end
      end
   end

   // ==========================================================
   // AXI4-Lite slave: address and data taken together, one of each outstanding
   assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_wready = s_axi_awready;
   assign wr_fire = s_axi_awready;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_enable <= `SRD_CTRL_ENABLE_RESET;
         mac_count <= `SRD_MAC_COUNT_RESET;
      end
      else if (wr_fire && s_axi_wstrb[0])
      begin
         if (s_axi_awaddr == `SRD_OFF_CTRL)
            ctrl_enable <= s_axi_wdata[0];
         if (s_axi_awaddr == `SRD_OFF_MAC_COUNT)
            mac_count <= s_axi_wdata[7:0];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SRD_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (s_axi_awaddr > `SRD_OFF_OPCODE || s_axi_awaddr[1:0] != 2'h0) ? `SRD_RESP_SLVERR
                                                                                         : `SRD_RESP_OKAY;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SRD_RESP_OKAY;
      end
      else if (rd_fire)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `SRD_RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         unique case (s_axi_araddr)
            `SRD_OFF_CTRL: s_axi_rdata <= {31'h0000_0000, ctrl_enable};
            `SRD_OFF_MAC_COUNT: s_axi_rdata <= {24'h00_0000, mac_count};
            `SRD_OFF_STACK_PTR: s_axi_rdata <= {16'h0000, stack_pointer};
            `SRD_OFF_STATUS: s_axi_rdata <= {30'h0000_0000, insn_illegal, state != st_idle};
            `SRD_OFF_RESULT: s_axi_rdata <= {8'h00, insn_cycles, insn_len, insn_op};
            `SRD_OFF_OPCODE: s_axi_rdata <= {16'h0000, first_q, second_q};
            default: s_axi_rresp <= `SRD_RESP_SLVERR;
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_imm_push_timing: assert property (insn_done && insn_op == srd_op_push_imm |->
      insn_cycles == 16'h0002 && (insn_len == 4'h3 || insn_len == 4'h4)) else $error("immediate push timing");
   a_opnd_reg_cycles: assert property (insn_done && insn_op == srd_op_push_opnd && insn_sel[3:1] != 3'b011
      && insn_sel[3] == 1'b0 |-> insn_cycles == 16'h0002 && insn_len == 4'h2) else $error("operand push reg");
   a_short_push_len: assert property (insn_done && (insn_op == srd_op_push_short_b ||
      insn_op == srd_op_push_short_w) |-> insn_len == 4'h1 && insn_cycles == 16'h0002) else $error("short push");
   a_ea_memory_only: assert property (insn_done && insn_op == srd_op_push_effective_address &&
      !insn_illegal |-> insn_sel[3] && insn_cycles == 16'h0002) else $error("effective address push");
   a_ctrl_code_zero: assert property (insn_done && insn_op == srd_op_push_control_reg
      && insn_sel == 4'h0 |-> insn_illegal && !stack_wr_en) else $error("control code zero accepted");
   a_set_push_cycles: assert property (insn_done && insn_op == srd_op_push_register_set |->
      insn_cycles == ((set_cnt_q == 4'h0) ? 16'h0001 : 16'(set_cnt_q) * 16'h0002)) else $error("set push cycles");
   a_mac_word_cycles: assert property (insn_done && insn_op == srd_op_repeat_multiply_accumulate
      && first_q[0] |-> insn_cycles == 16'h0006 + 16'h0009 * 16'(mac_count)) else $error("mac word cycles");
   a_rot_reg_cycles: assert property (insn_done && insn_op == srd_op_rotate_left_through_carry
      && insn_sel[3:2] == 2'b00 |-> insn_cycles == 16'h0001) else $error("rotate reg cycles");
   a_sp_before_store: assert property (stack_wr_en |->
      stack_pointer == stack_wr_addr && $past(stack_pointer) == stack_wr_addr + 16'(stack_wr_bytes))
      else $error("stack pointer not dropped");
   a_exec_stall_len: assert property ($rose(state == st_exec) |-> !fetch_ready [*2] or
      ##1 insn_done) else $error("fetch not stalled");
endmodule

// file: srd_top_tb.sv
`timescale 1ns/100ps
`include "srd_defs.svh"
module srd_top_tb;
   import srd_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [4:0] awaddr, araddr, stack_wr_bytes;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [7:0] fetch_byte;
   logic fetch_valid, fetch_ready, insn_done, insn_illegal, stack_wr_en;
   srd_op_type insn_op;
   srd_kind_type insn_kind;
   logic [3:0] insn_sel, insn_len;
   logic [15:0] insn_cycles, stack_wr_addr;
   int num_errors = 0;
   int n_tests = 0;
   srd_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fetch_valid(fetch_valid),
      .fetch_byte(fetch_byte), .fetch_ready(fetch_ready), .insn_done(insn_done), .insn_op(insn_op),
      .insn_kind(insn_kind), .insn_sel(insn_sel), .insn_len(insn_len), .insn_cycles(insn_cycles),
      .insn_illegal(insn_illegal), .stack_wr_en(stack_wr_en), .stack_wr_addr(stack_wr_addr),
      .stack_wr_bytes(stack_wr_bytes));
   srd_fetch_model u_fm (.aclk(aclk), .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
      .fetch_byte(fetch_byte));
   // ==========================================================
   // Shared tasks
   task final_report;
      if (num_errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic tick(inout int i);
      @(posedge aclk);
      i++;
      if (i > 200)
      begin
         num_errors++;
         final_report;
      end
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic axw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er = `SRD_RESP_OKAY);
      int i;
      i = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      tick(i);
      while (awready !== 1'b1 || wready !== 1'b1) tick(i);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      tick(i);
      while (bvalid !== 1'b1) tick(i);
      bready <= 1'b0;
      chk("bresp", er, bresp);
   endtask
   task automatic axr(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
      int i;
      i = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      tick(i);
      while (arready !== 1'b1) tick(i);
      arvalid <= 1'b0;
      tick(i);
      while (rvalid !== 1'b1) tick(i);
      rready <= 1'b0;
      chk("rdata", ed, rdata);
      chk("rresp", er, rresp);
   endtask
   // Cycle count runs from queue load: one edge to offer, len bytes, N busy ending in done, sample
   task automatic run(input logic [7:0] b[$], input logic [3:0] op, input logic [3:0] len,
      input logic [15:0] cyc, input logic ill, input logic [4:0] sb);
      int i;
      i = 0;
      @(negedge aclk);
      u_fm.q = b;
      tick(i);
      while (insn_done !== 1'b1) tick(i);
      if (!ill)
      begin
         chk("edges_to_done", len + cyc + 2, i);
         chk("op", op, insn_op);
         chk("len", len, insn_len);
         chk("cycles", cyc, insn_cycles);
      end
      chk("illegal", ill, insn_illegal);
      chk("stack_en", sb != 0, stack_wr_en);
      if (sb != 0)
         chk("stack_bytes", sb, stack_wr_bytes);
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_regs;
      axr(`SRD_OFF_CTRL, 32'h0000_0001, `SRD_RESP_OKAY);
      axr(`SRD_OFF_MAC_COUNT, 32'h0000_0000, `SRD_RESP_OKAY);
      axr(`SRD_OFF_STACK_PTR, 32'h0000_0000, `SRD_RESP_OKAY);
      axr(5'h18, 32'h0000_0000, `SRD_RESP_SLVERR);
      axw(5'h18, 32'h0000_0000, `SRD_RESP_SLVERR);
      axw(`SRD_OFF_CTRL, 32'h0000_0000);
      @(posedge aclk);
      chk("fetch_ready", 1'b0, fetch_ready);
      axw(`SRD_OFF_CTRL, 32'h0000_0001);
      axw(`SRD_OFF_STACK_PTR, 32'h0000_0010);
   endtask
   task automatic t_short;
      run('{8'h82}, 4'h3, 4'h1, 16'h0002, 1'b0, 5'h01);
      chk("sp", 16'h000F, stack_wr_addr);
      run('{8'hCA}, 4'h4, 4'h1, 16'h0002, 1'b0, 5'h02);
      chk("sp", 16'h000D, stack_wr_addr);
   endtask
   task automatic t_general;
      run('{8'h7D, 8'hE2, 8'h34, 8'h12}, 4'h1, 4'h4, 16'h0002, 1'b0, 5'h02);
      run('{8'h74, 8'h40}, 4'h2, 4'h2, 16'h0002, 1'b0, 5'h01);
      run('{8'h75, 8'h48, 8'h05}, 4'h2, 4'h3, 16'h0004, 1'b0, 5'h02);
      chk("kind", srd_kind_displacement_byte, insn_kind);
      run('{8'h74, 8'h4F, 8'h00, 8'h20}, 4'h2, 4'h4, 16'h0004, 1'b0, 5'h01);
   endtask
   task automatic t_ea_ctrl;
      run('{8'h7D, 8'h90}, 4'h0, 4'h2, 16'h0001, 1'b1, 5'h00);
      run('{8'h7D, 8'h9F, 8'h00, 8'h10}, 4'h5, 4'h4, 16'h0002, 1'b0, 5'h02);
      run('{8'hEB, 8'h02}, 4'h0, 4'h2, 16'h0001, 1'b1, 5'h00);
      run('{8'hEB, 8'h52}, 4'h6, 4'h2, 16'h0002, 1'b0, 5'h02);
      chk("ctrl_sel", 4'h5, insn_sel);
   endtask
   task automatic t_set_mac_rot;
      run('{8'hEC, 8'hC5}, 4'h7, 4'h2, 16'h0008, 1'b0, 5'h08);
      axw(`SRD_OFF_MAC_COUNT, 32'h0000_0003);
      run('{8'h7C, 8'hF1}, 4'h8, 4'h2, 16'h0019, 1'b0, 5'h00);
      run('{8'h7D, 8'hF1}, 4'h8, 4'h2, 16'h0021, 1'b0, 5'h00);
      run('{8'h77, 8'hA0}, 4'h9, 4'h2, 16'h0001, 1'b0, 5'h00);
      run('{8'h76, 8'hA6}, 4'h9, 4'h2, 16'h0003, 1'b0, 5'h00);
      axr(`SRD_OFF_RESULT, 32'h0000_0329, `SRD_RESP_OKAY);
      axr(`SRD_OFF_OPCODE, 32'h0000_76A6, `SRD_RESP_OKAY);
   endtask
   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      awaddr = 5'h00;
      araddr = 5'h00;
      wdata = 32'h0000_0000;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_short;
      t_general;
      t_ea_ctrl;
      t_set_mac_rot;
      final_report;
   end
endmodule
